// ---- core/eipl_top.v ----
// Extended priority register and two external interrupt requests.
// Assumes an AXI4-Lite master on aclk and vector acks from the core.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "eipl_regs.vh"

module eipl_top #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // Port 0 pins
  input  wire [7:0]        port_zero_pins,
  // Vectoring acknowledges from the core
  input  wire              ext_zero_vector,
  input  wire              ext_one_vector,
  // Requests to the core
  output wire              ext_request_zero,
  output wire              ext_request_one,
  // Priority levels to the vectoring logic
  output wire              timer_three_prio,
  output wire              comparator_prio,
  output wire              counter_array_prio,
  output wire              conversion_done_prio,
  output wire              window_compare_prio,
  output wire              port_match_prio,
  output wire              two_wire_bus_prio
);

  localparam SEL_NONE = 3'h0;
  localparam SEL_PRIO = 3'h1;
  localparam SEL_CFG  = 3'h2;
  localparam SEL_TCTL = 3'h3;
  localparam SEL_MASK = 3'h4;

  localparam [3:0] RST_TCTL = `EIPL_RST_TCTL;

  // ========================================================================
  // Address decode, shared by both channels
  function [2:0] eipl_sel;
    input [ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        eipl_sel = SEL_NONE;
      end else if (addr[ADDR_W-1:2] == `EIPL_IDX_PRIO) begin
        eipl_sel = SEL_PRIO;
      end else if (addr[ADDR_W-1:2] == `EIPL_IDX_CFG) begin
        eipl_sel = SEL_CFG;
      end else if (addr[ADDR_W-1:2] == `EIPL_IDX_TCTL) begin
        eipl_sel = SEL_TCTL;
      end else if (addr[ADDR_W-1:2] == `EIPL_IDX_MASK) begin
        eipl_sel = SEL_MASK;
      end else begin
        eipl_sel = SEL_NONE;
      end
    end
  endfunction

  reg  [7:0]  prio_q;
  reg  [7:0]  cfg_q;
  reg         zero_trig_q;
  reg         one_trig_q;
  reg  [1:0]  mask_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [1:0]  rresp_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;

  wire        wr_fire;
  wire        rd_fire;
  wire [2:0]  wr_sel;
  wire [2:0]  rd_sel;
  wire        lane0;
  wire        tctl_wr;
  wire [7:0]  pins_sync;
  wire        zero_pending;
  wire        one_pending;

  // ========================================================================
  // Write channel: address and data taken together, response next cycle
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign wr_sel        = eipl_sel(s_axi_awaddr);
  assign lane0         = s_axi_wstrb[0];
  assign tctl_wr       = wr_fire && lane0 && (wr_sel == SEL_TCTL);

  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `EIPL_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == SEL_NONE) ? `EIPL_RESP_SLVERR : `EIPL_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ========================================================================
  // Register storage; reserved bit 6 is stored as written
  always @(posedge aclk) begin
    if (!aresetn) begin
      prio_q      <= `EIPL_RST_PRIO;
      cfg_q       <= `EIPL_RST_CFG;
      zero_trig_q <= RST_TCTL[`EIPL_B_ZERO_TRIG];
      one_trig_q  <= RST_TCTL[`EIPL_B_ONE_TRIG];
      mask_q      <= `EIPL_RST_MASK;
    end else if (wr_fire && lane0) begin
      if (wr_sel == SEL_PRIO) begin
        prio_q <= s_axi_wdata[7:0]; // R1 R3 R4 R5 R6 R7 R8
      end else if (wr_sel == SEL_CFG) begin
        cfg_q <= s_axi_wdata[7:0]; // R9 R18
      end else if (wr_sel == SEL_TCTL) begin
        zero_trig_q <= s_axi_wdata[`EIPL_B_ZERO_TRIG]; // R9
        one_trig_q  <= s_axi_wdata[`EIPL_B_ONE_TRIG];
      end else if (wr_sel == SEL_MASK) begin
        mask_q <= s_axi_wdata[1:0];
      end
    end
  end

  // ========================================================================
  // Read channel: one read in flight, data registered
  assign s_axi_arready = !rvalid_q;
  assign rd_fire       = s_axi_arvalid && !rvalid_q;
  assign rd_sel        = eipl_sel(s_axi_araddr);

  always @* begin
    rdata_d = 32'h0000_0000;
    if (rd_sel == SEL_PRIO) begin
      rdata_d[7:0] = prio_q;
    end else if (rd_sel == SEL_CFG) begin
      rdata_d[7:0] = cfg_q;
    end else if (rd_sel == SEL_TCTL) begin
      rdata_d[`EIPL_B_ZERO_TRIG] = zero_trig_q;
      rdata_d[`EIPL_B_ZERO_PEND] = zero_pending; // R13
      rdata_d[`EIPL_B_ONE_TRIG]  = one_trig_q;
      rdata_d[`EIPL_B_ONE_PEND]  = one_pending; // R13
    end else if (rd_sel == SEL_MASK) begin
      rdata_d[1:0] = mask_q;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `EIPL_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_sel == SEL_NONE) ? `EIPL_RESP_SLVERR : `EIPL_RESP_OKAY;
      rdata_q  <= rdata_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ========================================================================
  // External requests; pins are only read, never driven
  eipl_pin_sync #(
    .WIDTH     (8)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pins_in   (port_zero_pins), // R11
    .pins_sync (pins_sync)
  );

  eipl_ext_detect u_zero (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .pins_sync    (pins_sync),
    .pin_select   (cfg_q[`EIPL_F_ZERO_SEL]),
    .polarity     (cfg_q[`EIPL_B_ZERO_POL]),
    .trigger_type (zero_trig_q),
    .vector_ack   (ext_zero_vector),
    .sw_write     (tctl_wr),
    .sw_value     (s_axi_wdata[`EIPL_B_ZERO_PEND]),
    .pending      (zero_pending)
  );

  eipl_ext_detect u_one (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .pins_sync    (pins_sync),
    .pin_select   (cfg_q[`EIPL_F_ONE_SEL]),
    .polarity     (cfg_q[`EIPL_B_ONE_POL]),
    .trigger_type (one_trig_q),
    .vector_ack   (ext_one_vector),
    .sw_write     (tctl_wr),
    .sw_value     (s_axi_wdata[`EIPL_B_ONE_PEND]),
    .pending      (one_pending)
  );

  // Mask gates the flag, not the flag's capture
  assign ext_request_zero = zero_pending && mask_q[`EIPL_B_ZERO_MASK]; // R19
  assign ext_request_one  = one_pending && mask_q[`EIPL_B_ONE_MASK]; // R19

  // ========================================================================
  // Priority levels
  assign timer_three_prio     = prio_q[`EIPL_B_TIMER3]; // R1
  assign comparator_prio      = prio_q[`EIPL_B_CMP]; // R3
  assign counter_array_prio   = prio_q[`EIPL_B_PCA]; // R4
  assign conversion_done_prio = prio_q[`EIPL_B_CONV]; // R5
  assign window_compare_prio  = prio_q[`EIPL_B_WIN]; // R6
  assign port_match_prio      = prio_q[`EIPL_B_MATCH]; // R7
  assign two_wire_bus_prio    = prio_q[`EIPL_B_TWI]; // R8

endmodule // eipl_top

// ---- core/eipl_regs.vh ----
// Constants for the extended interrupt priority and external request block.
// Assumes inclusion by bare name; definitions only.
//
// What this block does
// [R1] Priority bit 7 sets timer three interrupt low (0) or high (1).
// [R2] Software writes zero into reserved priority bit 6.
// [R3] Priority bit 5 sets comparator interrupt low or high.
// [R4] Priority bit 4 sets counter array interrupt low or high.
// [R5] Priority bit 3 sets conversion-complete interrupt low or high.
// [R6] Priority bit 2 sets window-compare interrupt low or high.
// [R7] Priority bit 1 sets port match interrupt low or high.
// [R8] Priority bit 0 sets two-wire bus interrupt low or high.
// [R9] Each external request has its own polarity and trigger-type bit.
// [R10] Trigger type 1 is edge, 0 level; polarity 0 low, 1 high.
// [R11] Each request samples its pin without disturbing the crossbar peripheral.
// [R12] Software sets crossbar skip to dedicate a pin to a request.
// [R13] Pending flags sit at timer control bit 1 and bit 3.
// [R14] Edge mode pending flag clears when the CPU vectors.
// [R15] Level mode pending flag follows the active level of the input.
// [R16] Source holds a level request until the device recognises it.
// [R17] Source drops a level request before service ends, else re-request.
// [R18] Three-bit select picks one of eight port 0 pins, 000 to 111.
// [R19] A request reaches the CPU only while its mask bit is set.
// [R20] Pins are synchronised; edge mode catches entry into active level.
`ifndef EIPL_REGS_VH
`define EIPL_REGS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define EIPL_IDX_PRIO        10'h0f6
`define EIPL_IDX_CFG         10'h0e4
`define EIPL_IDX_TCTL        10'h0f0
`define EIPL_IDX_MASK        10'h0f1

// ==========================================================================
// Reset values
`define EIPL_RST_PRIO        8'h00
`define EIPL_RST_CFG         8'h01
`define EIPL_RST_TCTL        4'h0
`define EIPL_RST_MASK        2'h0

// ==========================================================================
// Priority register fields
`define EIPL_B_TIMER3        7
`define EIPL_B_RSVD          6
`define EIPL_B_CMP           5
`define EIPL_B_PCA           4
`define EIPL_B_CONV          3
`define EIPL_B_WIN           2
`define EIPL_B_MATCH         1
`define EIPL_B_TWI           0

// ==========================================================================
// Request configuration fields
`define EIPL_B_ONE_POL       7
`define EIPL_F_ONE_SEL       6:4
`define EIPL_B_ZERO_POL      3
`define EIPL_F_ZERO_SEL      2:0

// ==========================================================================
// Timer control fields (only the request bits live here)
`define EIPL_B_ZERO_TRIG     0
`define EIPL_B_ZERO_PEND     1
`define EIPL_B_ONE_TRIG      2
`define EIPL_B_ONE_PEND      3

// ==========================================================================
// Mask register fields
`define EIPL_B_ZERO_MASK     0
`define EIPL_B_ONE_MASK      1

// ==========================================================================
// Bus answers and pipeline depth
`define EIPL_RESP_OKAY       2'h0
`define EIPL_RESP_SLVERR     2'h2
`define EIPL_SYNC_STAGES     2

`endif

// ---- core/eipl_pin_sync.v ----
// Two-stage synchroniser for the port 0 pins.
// Assumes pins change at any time relative to aclk.
`timescale 1ns/1ps
`include "eipl_regs.vh"

module eipl_pin_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Pins
  input  wire [WIDTH-1:0] pins_in,
  output wire [WIDTH-1:0] pins_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // ========================================================================
  // First stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= pins_in; // R20
      sync_q <= meta_q;
    end
  end

  assign pins_sync = sync_q;

endmodule // eipl_pin_sync

// ---- core/eipl_ext_detect.v ----
// One external request: pin select, polarity, edge or level pending flag.
// Assumes pins_sync is already synchronous to aclk.
`timescale 1ns/1ps
`include "eipl_regs.vh"

module eipl_ext_detect (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Synchronised port 0
  input  wire [7:0] pins_sync,
  // Configuration
  input  wire [2:0] pin_select,
  input  wire       polarity,
  input  wire       trigger_type,
  // Events
  input  wire       vector_ack,
  input  wire       sw_write,
  input  wire       sw_value,
  // Flag
  output wire       pending
);

  wire pin_level;
  wire active;
  reg  prev_q;
  reg  pending_q;
  reg  pending_d;

  // ========================================================================
  // Pin pick and active level
  assign pin_level = pins_sync[pin_select]; // R18 R11
  assign active    = polarity ? pin_level : ~pin_level; // R9 R10

  // ========================================================================
  // Flag update; a new edge wins over any clear in the same cycle
  always @* begin
    pending_d = pending_q;
    if (!trigger_type) begin
      pending_d = active; // R15 R10
    end else if (active && !prev_q) begin
      pending_d = 1'b1; // R20
    end else if (vector_ack) begin
      pending_d = 1'b0; // R14
    end else if (sw_write) begin
      pending_d = sw_value;
    end
  end

  // Previous level resets active so a pin idling active gives no false edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q    <= 1'b1;
      pending_q <= 1'b0;
    end else begin
      prev_q    <= active;
      pending_q <= pending_d;
    end
  end

  assign pending = pending_q;

endmodule // eipl_ext_detect

// ---- verification/eipl_top_sva.sv ----
// Checker for the priority register, bus answers and request outputs.
// Assumes it is bound to eipl_top and sees its ports only.
`timescale 1ns/1ps
module eipl_top_sva #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input logic              aclk,
  input logic              aresetn,
  // Register bus
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic [31:0]       s_axi_wdata,
  input logic [3:0]        s_axi_wstrb,
  input logic              s_axi_wvalid,
  input logic [1:0]        s_axi_bresp,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  // Pins and core side
  input logic [7:0]        port_zero_pins,
  input logic              ext_zero_vector,
  input logic              ext_one_vector,
  input logic              ext_request_zero,
  input logic              ext_request_one,
  input logic              timer_three_prio,
  input logic              comparator_prio,
  input logic              counter_array_prio,
  input logic              conversion_done_prio,
  input logic              window_compare_prio,
  input logic              port_match_prio,
  input logic              two_wire_bus_prio
);
  // ==========================================================
  // Shadow of trigger and mask bits, and a pin quiet counter
  logic       trig0_q, trig1_q, mask0_q;
  logic [7:0] pins_q;
  logic [1:0] quiet_q;
  wire        wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0];
  wire [6:0]  prio_vec = {timer_three_prio, comparator_prio, counter_array_prio,
                          conversion_done_prio, window_compare_prio, port_match_prio,
                          two_wire_bus_prio};

  always_ff @(posedge aclk) begin
    pins_q <= port_zero_pins;
    if (!aresetn) begin
      trig0_q <= 1'b0;
      trig1_q <= 1'b0;
      mask0_q <= 1'b0;
      quiet_q <= 2'h0;
    end else begin
      // Saturates at 3: a pin edge needs three edges to reach the flag
      if (port_zero_pins != pins_q) quiet_q <= 2'h0;
      else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
      if (wr_go && s_axi_awaddr == ADDR_W'(12'h3c0)) begin
        trig0_q <= s_axi_wdata[0];
        trig1_q <= s_axi_wdata[2];
      end
      if (wr_go && s_axi_awaddr == ADDR_W'(12'h3c4)) mask0_q <= s_axi_wdata[0];
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence prio_wr_s;
    wr_go && s_axi_awaddr == ADDR_W'(12'h3d8);
  endsequence

  prio_write_a: assert property (prio_wr_s |=> prio_vec == $past({s_axi_wdata[7], s_axi_wdata[5:0]}))
    else $error("priority outputs differ from written bits");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid)
    else $error("write response late");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped early");
  mask_gate_a: assert property (ext_request_zero |-> mask0_q)
    else $error("request zero while masked");
  edge_clear_a: assert property (trig0_q && ext_zero_vector && quiet_q == 2'h3 && !wr_go |=> !ext_request_zero)
    else $error("edge pending not cleared by vector");
  level_keep_a: assert property (!trig1_q && ext_request_one && ext_one_vector && quiet_q == 2'h3 |=> ext_request_one)
    else $error("level pending cleared by vector");
endmodule // eipl_top_sva

bind eipl_top eipl_top_sva #(.ADDR_W(ADDR_W)) eipl_top_sva_i (.*);

// ---- verification/eipl_pin_source.sv ----
// External source model driving the eight port 0 pins.
// Assumes the caller sequences requests; pins move just after an edge.
`timescale 1ns/1ps
module eipl_pin_source (
  // Clock
  input  logic       aclk,
  // Pins
  output logic [7:0] port_zero_pins
);
  // Pins are dedicated to the requests: no crossbar peripheral drives them
  initial port_zero_pins = 8'hff;
  task automatic set_all(input logic [7:0] v);
    @(posedge aclk);
    port_zero_pins <= v;
  endtask
  task automatic set_pin(input logic [2:0] idx, input logic v);
    @(posedge aclk);
    port_zero_pins[idx] <= v;
  endtask
endmodule // eipl_pin_source

// ---- verification/tb.sv ----
// Testbench: register bus tasks plus pin stimulus for eipl_top.
// Assumes the checker binds itself; pins come from eipl_pin_source.
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        ext_zero_vector = 1'b0, ext_one_vector = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [7:0]   port_zero_pins;
  wire         ext_request_zero, ext_request_one, timer_three_prio, comparator_prio;
  wire         counter_array_prio, conversion_done_prio, window_compare_prio;
  wire         port_match_prio, two_wire_bus_prio;
  wire [6:0]   prio = {timer_three_prio, comparator_prio, counter_array_prio,
                       conversion_done_prio, window_compare_prio, port_match_prio,
                       two_wire_bus_prio};
  logic [7:0]  e;
  int          mismatches = 0, cmp_count = 0;

  eipl_top eipl_top_i (.*);
  eipl_pin_source eipl_pin_source_i (.aclk(aclk), .port_zero_pins(port_zero_pins));
  initial forever #5 aclk = ~aclk;

  // ==========================================================
  // Bus and check tasks
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for one handshake signal, sampled at the edge
  task automatic await(input int k);
    for (int n = 0; n < 99; n++) begin
      @(posedge aclk);
      if ((k == 0 && s_axi_awready && s_axi_wready) || (k == 1 && s_axi_bvalid) ||
          (k == 2 && s_axi_arready) || (k == 3 && s_axi_rvalid)) return;
    end
    mismatches++;
    wrap_up();
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    await(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    await(1);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    await(2);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    await(3);
    chk(s_axi_rdata, {24'h0, x});
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
  endtask
  task automatic vec(input logic one);
    {ext_one_vector, ext_zero_vector} <= one ? 2'b10 : 2'b01;
    @(posedge aclk);
    {ext_one_vector, ext_zero_vector} <= 2'b00;
    @(posedge aclk);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h3d8, 8'h00, 2'h0);
    rd(12'h390, 8'h01, 2'h0);
    rd(12'h3c0, 8'h00, 2'h0);
    rd(12'h3c4, 8'h00, 2'h0);
    rd(12'h004, 8'h00, 2'h2);
    wr(12'h004, 8'hff, 2'h2);
    for (int i = 0; i < 8; i++) begin
      e = 8'h01 << i;
      if (i != 6) begin
        wr(12'h3d8, e, 2'h0);
        rd(12'h3d8, e, 2'h0);
        chk({25'h0, prio}, {25'h0, e[7], e[5:0]});
      end
    end
    // Byte lane 0 off: the write is answered but leaves the register alone
    s_axi_wstrb <= 4'he;
    wr(12'h3d8, 8'h55, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h3d8, 8'h80, 2'h0);
    wr(12'h3c4, 8'h03, 2'h0);
    // Edge mode on request zero: every pin select under both polarities
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 8; s++) begin
        eipl_pin_source_i.set_all(p ? 8'h00 : 8'hff);
        repeat (4) @(posedge aclk);
        wr(12'h390, {4'h0, p[0], s[2:0]}, 2'h0);
        wr(12'h3c0, 8'h01, 2'h0);
        eipl_pin_source_i.set_pin(s[2:0], p[0]);
        repeat (5) @(posedge aclk);
        chk({31'h0, ext_request_zero}, 32'h1);
        // Request one stays level, active low on pin 0: its flag follows pin 0
        rd(12'h3c0, {4'h0, (p == 0) == (s == 0), 3'h3}, 2'h0);
        vec(1'b0);
        chk({31'h0, ext_request_zero}, 32'h0);
      end
    end
    // Level mode on request one, active high on pin 5
    wr(12'h3c4, 8'h01, 2'h0);
    eipl_pin_source_i.set_all(8'h00);
    wr(12'h390, 8'hd8, 2'h0);
    wr(12'h3c0, 8'h01, 2'h0);
    eipl_pin_source_i.set_pin(3'h5, 1'b1);
    repeat (5) @(posedge aclk);
    chk({31'h0, ext_request_one}, 32'h0);
    rd(12'h3c0, 8'h09, 2'h0);
    wr(12'h3c4, 8'h02, 2'h0);
    chk({31'h0, ext_request_one}, 32'h1);
    vec(1'b1);
    chk({31'h0, ext_request_one}, 32'h1);
    eipl_pin_source_i.set_pin(3'h5, 1'b0);
    repeat (5) @(posedge aclk);
    chk({31'h0, ext_request_one}, 32'h0);
    wrap_up();
  end
endmodule // tb
